// ### design/can_mob_irq_consts.vh
// Constants for the message object interrupt and prescaler block.
// Assumes an 8-bit SFR bus with byte addresses in the 0x80..0xFF range.
// Function
// - Read-only upper status shows objects 14..8 pending
// - Read-only lower status shows objects 7..0 pending
// - Upper enable bits gate objects 14..8 interrupts
// - Lower enable bits gate objects 7..0 interrupts
// - Reserved bits read indeterminate; software writes zero
// - Quantum period is prescaler plus one clocks
// - Prescaler undefined after reset; software programs it
// - Reset clears enables and upper status bits
`ifndef CAN_MOB_IRQ_CONSTS_VH
`define CAN_MOB_IRQ_CONSTS_VH

// SFR addresses
`define ADDR_BAUD_PRESCALER 8'hB4
`define ADDR_STATUS_HIGH    8'hBA
`define ADDR_STATUS_LOW     8'hBB
`define ADDR_ENABLE_HIGH    8'hC2
`define ADDR_ENABLE_LOW     8'hC3

// Field positions
`define PRESCALER_MSB       6
`define PRESCALER_LSB       1
`define UPPER_MSB           6

// Reset values
`define ENABLE_RESET        8'h00
`define PRESCALER_RESET     6'h00

// Object count
`define NUM_OBJECTS         15

`endif

// ### design/can_mob_irq_prescaler.v
// Message object interrupt status/enable registers and baud prescaler.
// Assumes a synchronous SFR bus on clock; object flags come from logic
// on the same clock and stay high until software clears their source.
`include "can_mob_irq_consts.vh"

module can_mob_irq_prescaler (
    // Clock and reset
    input  wire        clock,
    input  wire        rst_b,
    // SFR bus
    input  wire [7:0]  sfr_addr,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    input  wire [7:0]  sfr_wdata,
    output reg  [7:0]  sfr_rdata,
    output wire        sfr_hit,
    // Controller side
    input  wire        controller_enable,
    input  wire [14:0] obj_flags,
    // Outputs
    output wire        quantum_tick,
    output reg         can_irq,
    output wire [5:0]  quantum_divider
);

    reg        rst_meta;
    reg        rst_sync_b;
    reg [14:0] obj_pending;
    reg [6:0]  obj_irq_en_upper;
    reg [7:0]  obj_irq_en_lower;
    reg [5:0]  prescaler;
    reg [7:0]  next_rdata;

    // Decode helper used by write and read paths
    function is_addr;
        input [7:0] a;
        input [7:0] b;
        begin
            is_addr = (a == b);
        end
    endfunction

    // Reset release through two flip-flops
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // Pending bits follow the sticky object flags; they clear only
    // when software clears the underlying source condition
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            obj_pending <= 15'h0000;
        end else begin
            obj_pending <= obj_flags;
        end
    end

    // Enable registers; reserved bit 7 of upper is not stored
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            obj_irq_en_upper <= 7'h00;
            obj_irq_en_lower <= `ENABLE_RESET;
        end else if (sfr_wr) begin
            if (is_addr(sfr_addr, `ADDR_ENABLE_HIGH))
                obj_irq_en_upper <= sfr_wdata[`UPPER_MSB:0];
            if (is_addr(sfr_addr, `ADDR_ENABLE_LOW))
                obj_irq_en_lower <= sfr_wdata;
        end
    end

    // Prescaler has no reset: software must program it first.
    // Writes while the controller runs are ignored to protect timing.
    always @(posedge clock) begin
        if (sfr_wr && !controller_enable &&
            is_addr(sfr_addr, `ADDR_BAUD_PRESCALER))
            prescaler <= sfr_wdata[`PRESCALER_MSB:`PRESCALER_LSB];
    end

    assign quantum_divider = prescaler;

    // Interrupt request when any pending object is enabled
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b)
            can_irq <= 1'b0;
        else
            can_irq <= |(obj_pending &
                         {obj_irq_en_upper, obj_irq_en_lower});
    end

    // Read mux; reserved bits read as zero, one legal indeterminate value
    always @* begin
        next_rdata = 8'h00;
        if (is_addr(sfr_addr, `ADDR_STATUS_HIGH))
            next_rdata = {1'b0, obj_pending[14:8]};
        else if (is_addr(sfr_addr, `ADDR_STATUS_LOW))
            next_rdata = obj_pending[7:0];
        else if (is_addr(sfr_addr, `ADDR_ENABLE_HIGH))
            next_rdata = {1'b0, obj_irq_en_upper};
        else if (is_addr(sfr_addr, `ADDR_ENABLE_LOW))
            next_rdata = obj_irq_en_lower;
        else if (is_addr(sfr_addr, `ADDR_BAUD_PRESCALER))
            next_rdata = {1'b0, prescaler, 1'b0};
    end

    // Registered read data, one cycle after the read strobe
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b)
            sfr_rdata <= 8'h00;
        else if (sfr_rd)
            sfr_rdata <= next_rdata;
    end

    assign sfr_hit = is_addr(sfr_addr, `ADDR_STATUS_HIGH) |
                     is_addr(sfr_addr, `ADDR_STATUS_LOW) |
                     is_addr(sfr_addr, `ADDR_ENABLE_HIGH) |
                     is_addr(sfr_addr, `ADDR_ENABLE_LOW) |
                     is_addr(sfr_addr, `ADDR_BAUD_PRESCALER);

    // Time quantum generator
    quantum_divider_gen #(
        .WIDTH (6)
    ) u_quantum (
        .clock        (clock),
        .rst_sync_b   (rst_sync_b),
        .run          (controller_enable),
        .divider      (prescaler),
        .quantum_tick (quantum_tick)
    );

endmodule

// ### design/quantum_divider_gen.v
// Time quantum enable generator.
// Assumes the divider value is stable while the controller is enabled.
module quantum_divider_gen #(
    parameter WIDTH = 6
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rst_sync_b,
    // Control
    input  wire             run,
    input  wire [WIDTH-1:0] divider,
    // Output
    output reg              quantum_tick
);

    reg [WIDTH-1:0] count;

    // One tick every divider+1 clocks; restarts whenever the
    // controller is stopped, so a changed value takes effect cleanly
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            count        <= {WIDTH{1'b0}};
            quantum_tick <= 1'b0;
        end else if (!run) begin
            count        <= {WIDTH{1'b0}};
            quantum_tick <= 1'b0;
        end else if (count >= divider) begin
            count        <= {WIDTH{1'b0}};
            quantum_tick <= 1'b1;
        end else begin
            count        <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            quantum_tick <= 1'b0;
        end
    end

endmodule

// ### verif/can_mob_irq_monitor.sv
// Port assertions for the object interrupt and prescaler block.
// Bound into the top module; watches its ports only.
module can_mob_irq_monitor (
    // Clock, reset, bus
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        sfr_hit,
    // Controller side
    input wire logic        controller_enable,
    input wire logic [14:0] obj_flags,
    input wire logic        quantum_tick,
    input wire logic        can_irq,
    input wire logic [5:0]  quantum_divider
);
    timeunit 1ns/1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Decoded strobes; both enable registers share one address pair
    wire logic wr_div = sfr_wr && sfr_addr == 8'hB4;
    wire logic wr_en  = sfr_wr && sfr_addr[7:1] == 7'h61;
    wire logic rd_en  = sfr_rd && sfr_addr[7:1] == 7'h61;
    a_stat_low: assert property (sfr_rd && sfr_addr == 8'hBB |=>
        sfr_rdata == $past(obj_flags[7:0], 2)) else $error("status low");
    a_stat_high: assert property (sfr_rd && sfr_addr == 8'hBA |=>
        sfr_rdata[6:0] == $past(obj_flags[14:8], 2)) else $error("status hi");
    a_en_back: assert property (wr_en ##1 rd_en && $stable(sfr_addr)
        |=> sfr_rdata[6:0] == $past(sfr_wdata[6:0], 2)) else $error("enable");
    a_div_write: assert property (!controller_enable && wr_div |=>
        quantum_divider == $past(sfr_wdata[6:1])) else $error("div write");
    a_div_locked: assert property (controller_enable && wr_div |=>
        $stable(quantum_divider)) else $error("div locked");
    a_tick_pulse: assert property (quantum_tick && quantum_divider != 6'h00
        |=> !quantum_tick) else $error("tick width");
    a_tick_idle: assert property (!controller_enable [*3]
        |-> !quantum_tick) else $error("tick idle");
    a_irq_quiet: assert property ($past(obj_flags) == 15'h0000 &&
        $past(obj_flags, 2) == 15'h0000 |-> !can_irq) else $error("irq");
endmodule
bind can_mob_irq_prescaler can_mob_irq_monitor can_mob_irq_monitor_inst (.*);

// ### verif/cpu.sv
// CPU side model: one-cycle register bus strobes.
// Tasks are entered at a falling edge of clock.
module cpu (
    // Register bus
    input  wire logic       clock,
    input  wire logic [7:0] sfr_rdata,
    output logic      [7:0] sfr_addr  = 8'h00,
    output logic            sfr_wr    = 1'b0,
    output logic            sfr_rd    = 1'b0,
    output logic      [7:0] sfr_wdata = 8'h00
);
    timeunit 1ns/1ns;
    // Data is inverted after the strobe so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge clock);
        sfr_wr    = 1'b0;
        sfr_wdata = ~d;
    endtask
    // Read data is taken half a cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clock);
        sfr_rd   = 1'b0;
        d        = sfr_rdata;
    endtask
endmodule

// ### verif/testbench.sv
// Self-checking bench for the object interrupt and prescaler block.
// All register traffic goes through the CPU model.
module testbench;
    timeunit 1ns/1ns;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        controller_enable = 1'b0;
    logic [14:0] obj_flags = 15'h0000;
    wire  [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    wire         sfr_wr, sfr_rd, sfr_hit, quantum_tick, can_irq;
    wire  [5:0]  quantum_divider;
    logic [7:0]  d;
    logic [7:0]  rst_addr [4] = '{8'hBA, 8'hC2, 8'hC3, 8'hB0};
    int          failures = 0, cmp_count = 0, cycles = 0, i;
    cpu cpu_inst (.*);
    can_mob_irq_prescaler can_mob_irq_prescaler_inst (.*);
    always #50 clock = ~clock;
    // Hang guard
    always @(posedge clock) if (++cycles == 3000) begin
        failures++;
        close_out;
    end
    task chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %0t got %h want %h", $time, s, e);
        end
    endtask
    task close_out;
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Cleared registers, plus an unmapped place that reads zero
    task t_reset;
        foreach (rst_addr[k]) begin
            cpu_inst.rd(rst_addr[k], d);
            chk(d, 8'h00);
            chk({7'h00, sfr_hit}, (k == 3) ? 8'h00 : 8'h01);
            // Idle cycle so the read strobe is not raised as it drops
            @(negedge clock);
        end
    endtask
    // Write then read back at once; 0x0C to both enable registers, bit 7 never set
    task t_enable;
        cpu_inst.wr(8'hC2, 8'h0C);
        cpu_inst.rd(8'hC2, d);
        chk(d, 8'h0C);
        cpu_inst.wr(8'hC3, 8'h0C);
        cpu_inst.rd(8'hC3, d);
        chk(d, 8'h0C);
    endtask
    // Pending bits and the gated request
    task t_status;
        obj_flags = 15'h4C05;
        repeat (2) @(negedge clock);
        cpu_inst.rd(8'hBA, d);
        chk(d, 8'h4C);
        @(negedge clock);
        cpu_inst.rd(8'hBB, d);
        chk(d, 8'h05);
        chk({7'h00, can_irq}, 8'h01);
        obj_flags = 15'h4003;
        repeat (3) @(negedge clock);
        chk({7'h00, can_irq}, 8'h00);
    endtask
    // Divider 3 gives a tick every four clocks; locked while running
    task t_quantum;
        cpu_inst.wr(8'hB4, 8'h06);
        chk({2'h0, quantum_divider}, 8'h03);
        controller_enable = 1'b1;
        repeat (2) begin
            i = 0;
            @(negedge clock);
            while (quantum_tick !== 1'b1 && i < 40) begin
                @(negedge clock);
                i++;
            end
        end
        chk(8'(i), 8'h03);
        cpu_inst.wr(8'hB4, 8'h3E);
        chk({2'h0, quantum_divider}, 8'h03);
        controller_enable = 1'b0;
    endtask
    initial begin
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        repeat (3) @(negedge clock);
        t_reset;
        t_enable;
        t_status;
        t_quantum;
        close_out;
    end
endmodule
